// ===== jmf_coder_model.sv
// coder side sink that stalls at random or on hold
`default_nettype none
module jmf_coder_model (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [7:0] cd_data,
    input  wire logic       cd_valid,
    input  wire logic       hold,
    output var  logic       cd_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int         sd = 5;
    initial cd_ready = 1'b0;
    always @(negedge mclk)
        cd_ready <= !hold && rstn && ($random(sd) & 3) != 0;
    always @(posedge mclk)
        if (rstn && cd_valid && cd_ready)
            got.push_back(cd_data);
endmodule
`default_nettype wire

// ===== jmf_fifo.v
// synchronous fifo with valid and ready on both sides
`default_nettype none
module jmf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             mclk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    wire            mem_empty;

    assign mem_empty = (count == {(AW+1){1'b0}});
    assign in_ready  = (count != DEPTH[AW:0]);
    assign push      = in_valid && in_ready;
    // output register refills whenever memory holds data and the register is empty or being taken
    assign pop       = !mem_empty && (!out_valid || out_ready);

    always @(posedge mclk)
    begin
        if (push)
            mem[wptr] <= in_data;
    end

    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wptr <= wptr + 1'b1;
            if (pop)
            begin
                rptr     <= rptr + 1'b1;
                out_data <= mem[rptr];
            end
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== jmf_framer.v
// marker layer parser: byte stream in, unstuffed coded data and fields out
// Functional notes
// (RL1) at move: escape, 06h, four-byte line number field
// (RL2) then one horizontal offset byte, then one vertical offset byte
// (RL3) new length: escape, 05h, four-byte new vertical dimension
// (RL4) comment: escape, 07h, four-byte count, count bytes skipped
// (RL5) stripe ends with escape then 02h normal or reset code
// (RL6) coded data is byte stuffed so escape never starts a false marker
// (RL7) abort: escape, 04h, ends the image data stream early
// (RL8) escape then 01h is the reserved marker, never generated
// (RL9) stream is units of floating markers then one stripe entry
// (RL10) outside logic handles inter-stripe markers around the coder
// (RL11) after reset terminator outside logic reinitialises coder state
// (RL12) escape then 00h is a literal escape, other values are markers
`default_nettype none
`include "jmf_map.vh"
module jmf_framer (
    input  wire        mclk,
    input  wire        rstn,
    input  wire [7:0]  in_data,
    input  wire        in_valid,
    output wire        in_ready,
    output wire [7:0]  cd_data,
    output wire        cd_valid,
    input  wire        cd_ready,
    output reg  [31:0] at_line,
    output reg  [7:0]  at_x,
    output reg  [7:0]  at_y,
    output reg         at_stb,
    output reg  [31:0] new_lines,
    output reg         newlen_stb,
    output reg         stripe_end,
    output reg         stripe_reset,
    output reg         abort_seen,
    output reg         reserved_err,
    output reg         in_stripe
);
    // ************************************************
    // parser states
    // ************************************************
    localparam ST_DATA = 3'h0;
    localparam ST_ESC  = 3'h1;
    localparam ST_ATM  = 3'h2;
    localparam ST_NLEN = 3'h3;
    localparam ST_CLEN = 3'h4;
    localparam ST_CSKP = 3'h5;
    localparam ST_DONE = 3'h6;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [2:0]  idx;
    reg  [47:0] shreg;
    reg  [31:0] skip;
    reg  [7:0]  f_data;
    reg         f_valid;
    wire        f_ready;
    wire        take;
    wire        byte_ok;

    // ************************************************
    // coded data buffer toward the coder
    // ************************************************
    jmf_fifo #(
        .WIDTH (`JMF_FIFO_WIDTH),
        .DEPTH (`JMF_FIFO_DEPTH),
        .AW    (`JMF_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_data   (f_data),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (cd_data),
        .out_valid (cd_valid),
        .out_ready (cd_ready)
    );

    // stall input while a data byte cannot be pushed
    assign in_ready = (state != ST_DONE) && (!f_valid || f_ready);
    assign take     = in_valid && in_ready;
    assign byte_ok  = take;

    // ************************************************
    // next state
    // ************************************************
    always @*
    begin
        next_state = state;
        case (state)
            ST_DATA:
                if (take && in_data == `JMF_ESC)
                    next_state = ST_ESC;
            ST_ESC:
                if (take)
                begin
                    case (in_data)
                        `JMF_STUFF:   next_state = ST_DATA;  // [RL12] [RL6]
                        `JMF_ATMOVE:  next_state = ST_ATM;   // [RL1]
                        `JMF_NEWLEN:  next_state = ST_NLEN;  // [RL3]
                        `JMF_COMMENT: next_state = ST_CLEN;  // [RL4]
                        `JMF_ABORT:   next_state = ST_DONE;  // [RL7]
                        default:      next_state = ST_DATA;
                    endcase
                end
            ST_ATM:
                if (take && idx == `JMF_ATM_LEN - 3'h1)
                    next_state = ST_DATA;
            ST_NLEN:
                if (take && idx == `JMF_NEWLEN_LEN - 3'h1)
                    next_state = ST_DATA;
            ST_CLEN:
                if (take && idx == `JMF_CLEN_LEN - 3'h1)
                    next_state = ({shreg[23:0], in_data} == 32'h0) ?
                                 ST_DATA : ST_CSKP;
            ST_CSKP:
                if (take && skip == 32'h1)
                    next_state = ST_DATA;
            ST_DONE:
                next_state = ST_DONE;
            default:
                next_state = ST_DATA;
        endcase
    end

    // ************************************************
    // datapath and event pulses
    // ************************************************
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            state        <= ST_DATA;
            idx          <= 3'h0;
            shreg        <= 48'h0;
            skip         <= 32'h0;
            f_data       <= 8'h00;
            f_valid      <= 1'b0;
            at_line      <= 32'h0;
            at_x         <= 8'h00;
            at_y         <= 8'h00;
            at_stb       <= 1'b0;
            new_lines    <= 32'h0;
            newlen_stb   <= 1'b0;
            stripe_end   <= 1'b0;
            stripe_reset <= 1'b0;
            abort_seen   <= 1'b0;
            reserved_err <= 1'b0;
            in_stripe    <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            at_stb       <= 1'b0;
            newlen_stb   <= 1'b0;
            stripe_end   <= 1'b0;
            stripe_reset <= 1'b0;
            reserved_err <= 1'b0;
            if (f_valid && f_ready)
                f_valid <= 1'b0;
            if (byte_ok)
            begin
                shreg <= {shreg[39:0], in_data};
                if (state == ST_ATM || state == ST_NLEN || state == ST_CLEN)
                    idx <= idx + 3'h1;
                else
                    idx <= 3'h0;
                case (state)
                    ST_DATA:
                        if (in_data != `JMF_ESC)
                        begin
                            f_data    <= in_data;
                            f_valid   <= 1'b1;
                            in_stripe <= 1'b1;  // [RL9]
                        end
                    ST_ESC:
                        case (in_data)
                            `JMF_STUFF:
                            begin
                                f_data    <= `JMF_ESC;  // [RL12]
                                f_valid   <= 1'b1;
                                in_stripe <= 1'b1;
                            end
                            `JMF_SDNORM:
                            begin
                                stripe_end <= 1'b1;  // [RL5]
                                in_stripe  <= 1'b0;  // [RL9]
                            end
                            `JMF_SDRESET:
                            begin
                                stripe_end   <= 1'b1;  // [RL5]
                                stripe_reset <= 1'b1;  // [RL11]
                                in_stripe    <= 1'b0;
                            end
                            `JMF_ABORT:
                                abort_seen <= 1'b1;  // [RL7]
                            `JMF_ATMOVE, `JMF_NEWLEN, `JMF_COMMENT:
                                idx <= 3'h0;
                            default:
                                reserved_err <= 1'b1;  // [RL8]
                        endcase
                    ST_ATM:
                        if (idx == `JMF_ATM_LEN - 3'h1)
                        begin
                            at_line <= shreg[39:8];  // [RL1]
                            at_x    <= shreg[7:0];   // [RL2]
                            at_y    <= in_data;      // [RL2]
                            at_stb  <= 1'b1;
                        end
                    ST_NLEN:
                        if (idx == `JMF_NEWLEN_LEN - 3'h1)
                        begin
                            new_lines  <= {shreg[23:0], in_data};  // [RL3]
                            newlen_stb <= 1'b1;
                        end
                    ST_CLEN:
                        if (idx == `JMF_CLEN_LEN - 3'h1)
                            skip <= {shreg[23:0], in_data};  // [RL4]
                    ST_CSKP:
                        skip <= skip - 32'h1;  // [RL4]
                    default:
                        idx <= 3'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== jmf_framer_monitor.sv
// checker on the marker framer ports
`default_nettype none
module jmf_framer_monitor (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic [7:0] in_data,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire logic [7:0] cd_data,
    input wire logic       cd_valid,
    input wire logic       cd_ready,
    input wire logic       at_stb,
    input wire logic       newlen_stb,
    input wire logic       stripe_end,
    input wire logic       stripe_reset,
    input wire logic       abort_seen,
    input wire logic       reserved_err
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_abort_rise;
        !abort_seen ##1 abort_seen;
    endsequence
    a_abort_sticky: assert property (abort_seen |=> abort_seen)
        else $error("abort flag dropped");
    a_abort_stops: assert property (abort_seen |-> !in_ready)
        else $error("input taken after abort");
    a_abort_cause: assert property (s_abort_rise |->
        $past(in_valid) && $past(in_data) == 8'h04)
        else $error("abort without its code");
    a_term_code: assert property (stripe_end |->
        $past(in_data) inside {8'h02, 8'h03})
        else $error("stripe end on wrong code");
    a_reset_code: assert property (stripe_reset |->
        stripe_end && $past(in_data) == 8'h03)
        else $error("reset end on wrong code");
    a_at_pulse: assert property (at_stb |=> !at_stb)
        else $error("move strobe too long");
    a_nl_pulse: assert property (newlen_stb |=> !newlen_stb)
        else $error("length strobe too long");
    a_cd_hold: assert property (cd_valid && !cd_ready |=>
        cd_valid && $stable(cd_data))
        else $error("coded byte changed while stalled");
    a_rsv_cause: assert property (reserved_err |->
        !($past(in_data) inside {8'h00, [8'h02:8'h07]}))
        else $error("known code flagged");
endmodule
bind jmf_framer jmf_framer_monitor mon (.mclk, .rstn, .in_data, .in_valid,
    .in_ready, .cd_data, .cd_valid, .cd_ready, .at_stb, .newlen_stb,
    .stripe_end, .stripe_reset, .abort_seen, .reserved_err);
`default_nettype wire

// ===== jmf_framer_tb_top.sv
// self-checking bench for the marker segment framer
`default_nettype none
module jmf_framer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        in_valid = 1'b0;
    logic        hold = 1'b0;
    logic [7:0]  in_data = 8'h00;
    logic [7:0]  cd_data, at_x, at_y, b, ax, ay;
    logic [31:0] at_line, new_lines, lat, nl;
    logic        in_ready, cd_valid, cd_ready, at_stb, newlen_stb, in_stripe;
    logic        stripe_end, stripe_reset, abort_seen, reserved_err;
    logic [7:0]  exq[$];
    int          seed = 32'ha7ffd89b;
    int          err_total = 0, checked = 0;
    int          n, n_at, n_nl, n_end, n_rst, n_rsv;
    always #50 mclk = ~mclk;
    always @(posedge mclk)
    begin
        n_at += (at_stb === 1'b1);
        n_nl += (newlen_stb === 1'b1);
        n_end += (stripe_end === 1'b1);
        n_rst += (stripe_reset === 1'b1);
        n_rsv += (reserved_err === 1'b1);
    end
    jmf_framer uut (.mclk, .rstn, .in_data, .in_valid, .in_ready, .cd_data,
        .cd_valid, .cd_ready, .at_line, .at_x, .at_y, .at_stb, .new_lines,
        .newlen_stb, .stripe_end, .stripe_reset, .abort_seen, .reserved_err,
        .in_stripe);
    jmf_coder_model cm (.mclk, .rstn, .cd_data, .cd_valid, .hold, .cd_ready);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic put(logic [7:0] d);
        int k = 0;
        @(negedge mclk);
        in_data = d;
        in_valid = 1'b1;
        while (in_ready !== 1'b1 && k < 500)
        begin
            @(negedge mclk);
            k++;
        end
        if (k == 500)
        begin
            err_total++;
            give_verdict;
        end
        @(posedge mclk);
    endtask
    task automatic word(logic [31:0] w);
        for (int i = 3; i >= 0; i--)
            put(w[8*i +: 8]);
    endtask
    task automatic mrk(logic [7:0] c);
        put(8'hff);
        put(c);
    endtask
    // data bytes are stuffed and remembered for the coder side
    task automatic dat(logic [7:0] d);
        exq.push_back(d);
        put(d);
        if (d == 8'hff)
            put(8'h00);
    endtask
    task automatic idle;
        int k = 0;
        @(negedge mclk);
        in_valid = 1'b0;
        while (cm.got.size() < exq.size() && k < 400)
        begin
            @(negedge mclk);
            k++;
        end
        if (k == 400)
            err_total++;
        repeat (2) @(negedge mclk);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        chk("in_ready", 1, in_ready);
        chk("flags", 0, {at_stb, newlen_stb, stripe_end, abort_seen, in_stripe});
        for (int s = 0; s < 2; s++)
        begin
            lat = $random(seed);
            nl = $random(seed);
            {ax, ay} = 16'($random(seed));
            mrk(8'h06);
            word(lat);
            put(ax);
            put(ay);
            mrk(8'h05);
            word(nl);
            mrk(8'h07);
            word(32'h3);
            mrk(8'h02);
            put(8'h04);
            repeat (12) dat(8'($random(seed)));
            dat(8'hff);
            mrk(s ? 8'h09 : 8'h01);
            dat(8'h00);
            mrk(s ? 8'h02 : 8'h03);
            idle;
            chk("at_line", lat, at_line);
            chk("at_xy", {ax, ay}, {at_x, at_y});
            chk("new_lines", nl, new_lines);
            chk("in_stripe", 0, in_stripe);
        end
        chk("at_count", 2, n_at);
        chk("nl_count", 2, n_nl);
        chk("end_count", 2, n_end);
        chk("rst_count", 1, n_rst);
        chk("rsv_count", 2, n_rsv);
        // stall the coder and fill the buffer until input is refused
        hold <= 1'b1;
        n = 0;
        @(negedge mclk);
        while (in_ready === 1'b1 && n < 40)
        begin
            b = 8'($random(seed)) & 8'h7f;
            exq.push_back(b);
            in_data = b;
            in_valid = 1'b1;
            @(negedge mclk);
            n++;
        end
        in_valid = 1'b0;
        chk("fill_count", 34, n);
        hold <= 1'b0;
        idle;
        chk("cd_count", exq.size(), cm.got.size());
        foreach (exq[i])
            chk("cd_data", exq[i], cm.got[i]);
        mrk(8'h04);
        idle;
        chk("abort", 1, abort_seen);
        chk("ready_abort", 0, in_ready);
        give_verdict;
    end
    // watchdog cuts a hung run short
    initial
    begin
        #4000000;
        err_total++;
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== jmf_map.vh
// marker codes and framer constants for the marker segment framer
`ifndef JMF_MAP_VH
`define JMF_MAP_VH
`define JMF_ESC        8'hff
`define JMF_STUFF      8'h00
`define JMF_RESERVED   8'h01
`define JMF_SDNORM     8'h02
`define JMF_SDRESET    8'h03
`define JMF_ABORT      8'h04
`define JMF_NEWLEN     8'h05
`define JMF_ATMOVE     8'h06
`define JMF_COMMENT    8'h07
`define JMF_FIFO_WIDTH 8
`define JMF_FIFO_DEPTH 32
`define JMF_FIFO_AW    5
`define JMF_ATM_LEN    3'h6
`define JMF_NEWLEN_LEN 3'h4
`define JMF_CLEN_LEN   3'h4
`endif
